// *** rxf_pkg.sv ***
`default_nettype none
// ==========================================================================
// Shared constants for the receive filter control block
// ==========================================================================
package rxf_pkg;

  // ========================================================================
  // Bus geometry
  // ========================================================================
  localparam int unsigned RXF_DATA_W = 32;
  localparam int unsigned RXF_STRB_W = RXF_DATA_W / 8;

  // ========================================================================
  // Register offsets
  // ========================================================================
  localparam logic [17:0] RXF_CONTROL_OFFSET = 18'h00000;

  // ========================================================================
  // Field positions in rx_filter_control
  // ========================================================================
  localparam int unsigned RXF_BIT_REJECT_MCAST   = 1;
  localparam int unsigned RXF_BIT_REJECT_BCAST   = 2;
  localparam int unsigned RXF_BIT_NEWER_FN_EN    = 11;
  localparam int unsigned RXF_BIT_ENH_GROUP_EN   = 12;
  localparam int unsigned RXF_BIT_ACCEPT_ERR_EN  = 14;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [31:0] RXF_CONTROL_WR_MASK = 32'h0000_5806;
  localparam logic [31:0] RXF_CONTROL_RESET   = 32'h0000_0000;

  // ========================================================================
  // Bus responses
  // ========================================================================
  localparam logic [1:0] RXF_RESP_OKAY = 2'h0;

endpackage
`default_nettype wire

// *** rxf_frame_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Per-frame accept/drop decision driven by the control register
// ==========================================================================
module rxf_frame_gate
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Controls
  input  wire logic reject_mcast,
  input  wire logic reject_bcast,
  input  wire logic accept_errored_frames_en,
  // Frame verdict request
  input  wire logic frame_done,
  input  wire logic frame_is_mcast,
  input  wire logic frame_is_bcast,
  input  wire logic frame_errored,
  // Frame verdict answer
  output logic      frame_accept,
  output logic      frame_drop
);
  import rxf_pkg::*;

  typedef struct packed {
    logic accept;
    logic drop;
  } rxf_gate_state_type;

  rxf_gate_state_type state_reg;
  rxf_gate_state_type state_next;

  logic drop_now;

  always_comb
  begin
    // Group rejection ignores the address table contents entirely
    // Broadcast is dropped by its own control and by the errored-frame term; the multicast term drops it only when frame_is_mcast is also set
    drop_now = (frame_is_mcast & reject_mcast)
             | (frame_is_bcast & reject_bcast)
             | (frame_errored & ~accept_errored_frames_en);
    state_next        = '0;
    state_next.accept = frame_done & ~drop_now;
    state_next.drop   = frame_done & drop_now;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign frame_accept = state_reg.accept;
  assign frame_drop   = state_reg.drop;

endmodule
`default_nettype wire

// *** rxf_filter_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - With multicast rejection on, multicast frames are dropped whatever the address table holds.
// - The broadcast-reject control, when on, drops all broadcast frames; errored ones are also dropped while bit 14 is 0.
// - Each newer-function control bit resets to its disabling value so legacy behaviour holds.
// - Bits 31 to 15 and bit 13 always read as zero.
// - Bit 14 resets to 0 and, when set, passes errored frames on as though they were good.
// - Bit 12 resets to 0 and enables enhanced group filtering only when it was built in.
// - The register is reached over one memory-mapped lite bus as an offset from a base.
// - Bit 11 resets to 0 and, when set, enables the newer functions that were built in.
// ==========================================================================
// Receive filter control register with lite bus slave
// ==========================================================================
module rxf_filter_control
#(
  parameter int unsigned ADDR_W                      = 18,
  parameter bit          build_extended_group_filter = 1'b1
)
(
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rstn,
  // Write address channel
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  // Write data channel
  input  wire logic [rxf_pkg::RXF_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [rxf_pkg::RXF_STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  // Write response channel
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0]               s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  // Read data channel
  output logic [rxf_pkg::RXF_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // Controls towards the receive path
  output logic                                 reject_mcast,
  output logic                                 reject_bcast,
  output logic                                 accept_errored_frames_en,
  output logic                                 enhanced_group_filter_en,
  output logic                                 enhanced_group_filter_active,
  output logic                                 newer_functions_en,
  // Frame verdict request
  input  wire logic                            frame_done,
  input  wire logic                            frame_is_mcast,
  input  wire logic                            frame_is_bcast,
  input  wire logic                            frame_errored,
  // Frame verdict answer
  output logic                                 frame_accept,
  output logic                                 frame_drop
);
  import rxf_pkg::*;

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [RXF_DATA_W-1:0] control;
    logic                  bvalid;
    logic                  rvalid;
    logic [RXF_DATA_W-1:0] rdata;
  } rxf_state_type;

  rxf_state_type state_reg;
  rxf_state_type state_next;

  // ========================================================================
  // Internal signals
  // ========================================================================
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [RXF_DATA_W-1:0] byte_mask;
  logic [RXF_DATA_W-1:0] wr_merged;
  logic [RXF_DATA_W-1:0] rd_word;
  logic [ADDR_W-3:0]     wr_word_idx;
  logic [ADDR_W-3:0]     rd_word_idx;

  // ========================================================================
  // Bus handshakes
  // ========================================================================
  // Address and data are taken together so no write needs buffering;
  // a pending response stalls the next write
  // Reads and writes are independent; each waits only on its own response
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~state_reg.bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid & ~state_reg.rvalid;
  assign s_axi_arready = rd_fire;

  // Byte offsets inside a word are ignored; only the word index decodes
  assign wr_word_idx = s_axi_awaddr[ADDR_W-1:2];
  assign rd_word_idx = s_axi_araddr[ADDR_W-1:2];

  // Only word 0 is decoded; the rest reads zero and ignores writes
  assign wr_hit = (wr_word_idx == RXF_CONTROL_OFFSET[ADDR_W-1:2]);
  assign rd_hit = (rd_word_idx == RXF_CONTROL_OFFSET[ADDR_W-1:2]);

  // Strobes widen to one mask bit per data bit
  genvar gi;
  generate
    for (gi = 0; gi < RXF_STRB_W; gi++)
    begin : g_lane
      assign byte_mask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  // Reserved positions never take a written one
  assign wr_merged = (state_reg.control & ~(byte_mask & RXF_CONTROL_WR_MASK))
                   | (s_axi_wdata & byte_mask & RXF_CONTROL_WR_MASK);

  // ========================================================================
  // Read word
  // ========================================================================
  // Built per bit so a reserved position reads zero whatever is stored
  generate
    for (gi = 0; gi < RXF_DATA_W; gi++)
    begin : g_rd_bit
      if (RXF_CONTROL_WR_MASK[gi])
      begin : g_live
        assign rd_word[gi] = state_reg.control[gi];
      end
      else
      begin : g_zero
        assign rd_word[gi] = 1'b0;
      end
    end
  endgenerate

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb
  begin
    state_next = state_reg;
    // Write channel: the response stands until the master takes it
    if (wr_fire)
    begin
      if (wr_hit)
        state_next.control = wr_merged;
      state_next.bvalid = 1'b1;
    end
    else if (s_axi_bready)
      state_next.bvalid = 1'b0;

    // Read channel: data and valid stand until the master takes them
    if (rd_fire)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_hit ? rd_word : '0;
    end
    else if (s_axi_rready)
      state_next.rvalid = 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Reserved positions start at zero and no write can set them
      state_reg         <= '0;
      state_reg.control <= RXF_CONTROL_RESET;
    end
    else
      state_reg <= state_next;
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Every access answers OKAY, unmapped ones included
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp  = RXF_RESP_OKAY;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata  = state_reg.rdata;
  assign s_axi_rresp  = RXF_RESP_OKAY;

  // Controls are plain register bits, so they move only at a write edge
  assign reject_mcast             = state_reg.control[RXF_BIT_REJECT_MCAST];
  assign reject_bcast             = state_reg.control[RXF_BIT_REJECT_BCAST];
  assign accept_errored_frames_en = state_reg.control[RXF_BIT_ACCEPT_ERR_EN];
  assign enhanced_group_filter_en = state_reg.control[RXF_BIT_ENH_GROUP_EN];
  assign newer_functions_en       = state_reg.control[RXF_BIT_NEWER_FN_EN];

  // The enable is harmless in a build without the feature
  assign enhanced_group_filter_active = enhanced_group_filter_en & build_extended_group_filter;

  // ========================================================================
  // Frame verdict
  // ========================================================================
  // The gate judges each frame with the controls standing at its done edge
  rxf_frame_gate u_gate
  (
    .clk                      (clk),
    .rstn                     (rstn),
    .reject_mcast             (reject_mcast),
    .reject_bcast             (reject_bcast),
    .accept_errored_frames_en (accept_errored_frames_en),
    .frame_done               (frame_done),
    .frame_is_mcast           (frame_is_mcast),
    .frame_is_bcast           (frame_is_bcast),
    .frame_errored            (frame_errored),
    .frame_accept             (frame_accept),
    .frame_drop               (frame_drop)
  );

endmodule
`default_nettype wire

// *** rxf_filter_control_note_end.sv ***
`default_nettype none
`default_nettype wire

// *** rxf_filter_control_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port-level checks for the receive filter control block
// ==========================================================================
module rxf_filter_control_monitor
#(
  parameter bit build_extended_group_filter = 1'b1
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Controls
  input wire logic        reject_mcast,
  input wire logic        reject_bcast,
  input wire logic        accept_errored_frames_en,
  input wire logic        enhanced_group_filter_en,
  input wire logic        enhanced_group_filter_active,
  input wire logic        newer_functions_en,
  // Frame verdict
  input wire logic        frame_done,
  input wire logic        frame_is_mcast,
  input wire logic        frame_is_bcast,
  input wire logic        frame_errored,
  input wire logic        frame_accept,
  input wire logic        frame_drop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response missing one cycle after the write was taken");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read response missing one cycle after the read was taken");
  reserved_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_A7F9) == 32'h0)
    else $error("reserved bits read back nonzero");
  // Controls may only move at an edge that takes a write
  ctrl_hold_a: assert property (!(s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) |=>
    $stable({reject_mcast, reject_bcast, accept_errored_frames_en, enhanced_group_filter_en, newer_functions_en}))
    else $error("control changed without a write");
  enh_active_a: assert property (enhanced_group_filter_active == (enhanced_group_filter_en && build_extended_group_filter))
    else $error("enhanced filter active does not follow enable and build option");
  mcast_drop_a: assert property (frame_done && frame_is_mcast && reject_mcast |=> frame_drop && !frame_accept)
    else $error("multicast frame not dropped");
  bcast_drop_a: assert property (frame_done && frame_is_bcast && reject_bcast |=> frame_drop && !frame_accept)
    else $error("broadcast frame not dropped");
  bcast_only_a: assert property (frame_done && !frame_is_mcast && !frame_errored && !reject_bcast |=> frame_accept)
    else $error("broadcast frame dropped without broadcast reject");
  err_verdict_a: assert property (frame_done && frame_errored && !frame_is_mcast && !frame_is_bcast |=>
    frame_accept == $past(accept_errored_frames_en))
    else $error("errored frame verdict wrong");

  cover property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid);
  cover property (frame_done && frame_is_mcast && reject_mcast);
  cover property (frame_done && frame_errored && accept_errored_frames_en);
endmodule
`default_nettype wire

// *** rxf_filter_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the receive filter control register
// ==========================================================================
module rxf_filter_control_tb;
  import rxf_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        reject_mcast, reject_bcast, accept_errored_frames_en, enhanced_group_filter_en;
  logic        enhanced_group_filter_active, newer_functions_en, frame_accept, frame_drop;
  logic        frame_done, frame_is_mcast, frame_is_bcast, frame_errored;
  int          num_errors = 0;
  int          n_compared = 0;
  wire  [5:0]  ctrl = {reject_mcast, reject_bcast, accept_errored_frames_en, enhanced_group_filter_en,
                       enhanced_group_filter_active, newer_functions_en};

  rxf_filter_control #(.build_extended_group_filter(1'b1)) DUT
  (
    .clk                          (clk),
    .rstn                         (rstn),
    .s_axi_awaddr                 (s_axi_awaddr),
    .s_axi_awvalid                (s_axi_awvalid),
    .s_axi_awready                (s_axi_awready),
    .s_axi_wdata                  (s_axi_wdata),
    .s_axi_wstrb                  (s_axi_wstrb),
    .s_axi_wvalid                 (s_axi_wvalid),
    .s_axi_wready                 (s_axi_wready),
    .s_axi_bresp                  (s_axi_bresp),
    .s_axi_bvalid                 (s_axi_bvalid),
    .s_axi_bready                 (s_axi_bready),
    .s_axi_araddr                 (s_axi_araddr),
    .s_axi_arvalid                (s_axi_arvalid),
    .s_axi_arready                (s_axi_arready),
    .s_axi_rdata                  (s_axi_rdata),
    .s_axi_rresp                  (s_axi_rresp),
    .s_axi_rvalid                 (s_axi_rvalid),
    .s_axi_rready                 (s_axi_rready),
    .reject_mcast                 (reject_mcast),
    .reject_bcast                 (reject_bcast),
    .accept_errored_frames_en     (accept_errored_frames_en),
    .enhanced_group_filter_en     (enhanced_group_filter_en),
    .enhanced_group_filter_active (enhanced_group_filter_active),
    .newer_functions_en           (newer_functions_en),
    .frame_done                   (frame_done),
    .frame_is_mcast               (frame_is_mcast),
    .frame_is_bcast               (frame_is_bcast),
    .frame_errored                (frame_errored),
    .frame_accept                 (frame_accept),
    .frame_drop                   (frame_drop)
  );

  always #10 clk = ~clk;

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  // Bounded wait at falling edges; a flag that never rises ends the run
  task automatic wait_hi(input string name, ref logic flag);
    #1;
    for (int i = 0; i < 16 && flag !== 1'b1; i++)
      @(negedge clk);
    if (flag !== 1'b1)
    begin
      chk(name, 32'(flag), 32'h1);
      final_report();
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_wstrb = s;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    wait_hi("awready", s_axi_awready);
    chk("wready", 32'(s_axi_wready), 32'h1);
    @(negedge clk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    wait_hi("bvalid", s_axi_bvalid);
    chk("bresp", 32'(s_axi_bresp), 32'(RXF_RESP_OKAY));
    @(negedge clk);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    wait_hi("arready", s_axi_arready);
    @(negedge clk);
    s_axi_arvalid = 1'b0;
    wait_hi("rvalid", s_axi_rvalid);
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", 32'(s_axi_rresp), 32'(RXF_RESP_OKAY));
    @(negedge clk);
  endtask

  // Every flag combination back to back; the verdict of each shows one cycle later
  task automatic frames(input logic rm, input logic rb, input logic ae);
    logic [2:0] k;
    logic       d;
    frame_done = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      {frame_is_mcast, frame_is_bcast, frame_errored} = k;
      d = (k[2] & rm) | (k[1] & rb) | (k[0] & ~ae);
      @(negedge clk);
      chk("frame_drop", 32'(frame_drop), 32'(d));
      chk("frame_accept", 32'(frame_accept), 32'(!d));
    end
    frame_done = 1'b0;
  endtask

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {frame_done, frame_is_mcast, frame_is_bcast, frame_errored} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    chk("controls", 32'(ctrl), 32'h0);
    rd(RXF_CONTROL_OFFSET, 32'h0000_0000);
    frames(1'b0, 1'b0, 1'b0);
    wr(RXF_CONTROL_OFFSET, 32'hFFFF_FFFF, 4'hF);
    rd(RXF_CONTROL_OFFSET, 32'h0000_5806);
    chk("controls", 32'(ctrl), 32'h3F);
    frames(1'b1, 1'b1, 1'b1);
    wr(RXF_CONTROL_OFFSET, 32'h0000_1000, 4'h2);
    rd(RXF_CONTROL_OFFSET, 32'h0000_1006);
    chk("controls", 32'(ctrl), 32'h36);
    frames(1'b1, 1'b1, 1'b0);
    wr(18'h0_0004, 32'hFFFF_FFFF, 4'hF);
    rd(18'h0_0004, 32'h0000_0000);
    rd(RXF_CONTROL_OFFSET, 32'h0000_1006);
    wr(RXF_CONTROL_OFFSET, 32'h0000_0004, 4'hF);
    frames(1'b0, 1'b1, 1'b0);
    final_report();
  end
endmodule

bind rxf_filter_control rxf_filter_control_monitor #(.build_extended_group_filter(build_extended_group_filter)) u_mon
(
  .clk                          (clk),
  .rstn                         (rstn),
  .s_axi_awvalid                (s_axi_awvalid),
  .s_axi_wvalid                 (s_axi_wvalid),
  .s_axi_bvalid                 (s_axi_bvalid),
  .s_axi_arvalid                (s_axi_arvalid),
  .s_axi_rvalid                 (s_axi_rvalid),
  .s_axi_rdata                  (s_axi_rdata),
  .reject_mcast                 (reject_mcast),
  .reject_bcast                 (reject_bcast),
  .accept_errored_frames_en     (accept_errored_frames_en),
  .enhanced_group_filter_en     (enhanced_group_filter_en),
  .enhanced_group_filter_active (enhanced_group_filter_active),
  .newer_functions_en           (newer_functions_en),
  .frame_done                   (frame_done),
  .frame_is_mcast               (frame_is_mcast),
  .frame_is_bcast               (frame_is_bcast),
  .frame_errored                (frame_errored),
  .frame_accept                 (frame_accept),
  .frame_drop                   (frame_drop)
);
`default_nettype wire
